//--- verilog/dtp_top.sv
// dual 8-bit timer pair with cascade and square wave output
`timescale 1ns/1ps
module dtp_top
(
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   input  wire logic       ext_count_pin_in,
   output logic      [7:0] rdata_out,
   output logic            timer_out_pin_out,
   output logic            irq_lo_out,
   output logic            irq_hi_out
);
   typedef struct packed
   {
      logic [7:0] mode;
      logic [7:0] run;
      logic [7:0] cmp_lo;
      logic [7:0] cmp_lo_buf;
      logic [7:0] cmp_hi;
      logic       ff_inv;
      logic       ff_sel;
      logic       cmp_susp;
      logic [7:0] cnt_lo;
      logic [7:0] cnt_hi;
      logic       out_flop;
      logic       irq_lo;
      logic       irq_hi;
      logic [7:0] rdata;
   } dtp_state_t;

   dtp_state_t state_ff;
   dtp_state_t nxt_state;

   logic tap_div1;
   logic tap_div4;
   logic tap_div16;
   logic tap_div256;
   logic ext_rise;

   ////////////////////////////////////////////////////////////////////////
   dtp_prescaler u_pre
   (
      .sys_clk_in     (sys_clk_in),
      .rst_n_in       (rst_n_in),
      .run_in         (state_ff.run[dtp_pkg::RUN_PRE_BIT]),
      .tap_div1_out   (tap_div1),
      .tap_div4_out   (tap_div4),
      .tap_div16_out  (tap_div16),
      .tap_div256_out (tap_div256)
   );

   dtp_pin_sync u_sync
   (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .pin_in     (ext_count_pin_in),
      .rise_out   (ext_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] mode_f;
   logic [1:0] lo_sel;
   logic [1:0] hi_sel;
   logic       lo_run;
   logic       hi_run;
   logic       dbuf_en;
   logic       lo_tick;
   logic       hi_tick;
   logic       lo_step;
   logic [7:0] lo_inc;
   logic [7:0] hi_inc;
   logic       lo_eq;
   logic       lo_match8;
   logic       hi_step8;
   logic       hi_match8;
   logic       carry16;
   logic [7:0] hi_after;
   logic       match16;
   logic       ppg_step;
   logic       ppg_lo_eq;
   logic       ppg_hi_eq;
   logic       wr_ff_ctrl;
   logic [1:0] ff_cmd;

   assign mode_f  = state_ff.mode[dtp_pkg::MODE_LSB +: 2];
   assign lo_sel  = state_ff.mode[dtp_pkg::LO_CLK_LSB +: 2];
   assign hi_sel  = state_ff.mode[dtp_pkg::HI_CLK_LSB +: 2];
   assign lo_run  = state_ff.run[dtp_pkg::RUN_LO_BIT];
   assign hi_run  = state_ff.run[dtp_pkg::RUN_HI_BIT];
   assign dbuf_en = state_ff.run[dtp_pkg::RUN_DBUF_BIT];

   // lo clock: pin, div1, div4, div16
   assign lo_tick = (lo_sel == dtp_pkg::CLK_SEL_0) ? ext_rise :
                    (lo_sel == dtp_pkg::CLK_SEL_1) ? tap_div1 :
                    (lo_sel == dtp_pkg::CLK_SEL_2) ? tap_div4 : tap_div16;
   assign lo_step = lo_run & lo_tick;
   assign lo_inc  = state_ff.cnt_lo + 8'h01;
   assign hi_inc  = state_ff.cnt_hi + 8'h01;
   // a suspended compare masks every match until compare_hi is written
   assign lo_eq   = (lo_inc == state_ff.cmp_lo) & ~state_ff.cmp_susp;

   // 8-bit mode; compare value zero gives a 256 count period
   assign lo_match8 = (mode_f == dtp_pkg::MODE_8BIT) & lo_step & lo_eq;
   // hi clock: lo match, div1, div16, div256
   assign hi_tick = (hi_sel == dtp_pkg::CLK_SEL_0) ? lo_match8 :
                    (hi_sel == dtp_pkg::CLK_SEL_1) ? tap_div1 :
                    (hi_sel == dtp_pkg::CLK_SEL_2) ? tap_div16 : tap_div256;
   assign hi_step8  = (mode_f == dtp_pkg::MODE_8BIT) & hi_run & hi_tick;
   assign hi_match8 = hi_step8 & (hi_inc == state_ff.cmp_hi)
                      & ~state_ff.cmp_susp;

   // 16-bit mode: hi steps on lo overflow only
   assign carry16  = (mode_f == dtp_pkg::MODE_16BIT) & lo_step
                     & (state_ff.cnt_lo == 8'hff) & hi_run;
   assign hi_after = carry16 ? hi_inc : state_ff.cnt_hi;
   assign match16  = (mode_f == dtp_pkg::MODE_16BIT) & lo_step & hi_run
                     & lo_eq & ~state_ff.cmp_susp
                     & (hi_after == state_ff.cmp_hi);

   // square wave mode needs both run bits
   assign ppg_step  = (mode_f == dtp_pkg::MODE_PPG) & lo_step & hi_run;
   assign ppg_lo_eq = ppg_step & lo_eq;
   assign ppg_hi_eq = ppg_step & (lo_inc == state_ff.cmp_hi)
                      & ~state_ff.cmp_susp;

   assign wr_ff_ctrl = wr_in & (addr_in == dtp_pkg::ADDR_FFCTRL);
   assign ff_cmd     = wdata_in[dtp_pkg::FF_CMD_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state        = state_ff;
      nxt_state.irq_lo = 1'b0;
      nxt_state.irq_hi = 1'b0;
      nxt_state.rdata  = 8'h00;

      unique case (mode_f)
         dtp_pkg::MODE_8BIT:
         begin
            if (lo_step)
               nxt_state.cnt_lo = lo_match8 ? 8'h00 : lo_inc;
            if (hi_step8)
               nxt_state.cnt_hi = hi_match8 ? 8'h00 : hi_inc;
            nxt_state.irq_lo = lo_match8;
            nxt_state.irq_hi = hi_match8;
            if (state_ff.ff_inv &
                (state_ff.ff_sel ? hi_match8 : lo_match8))
               nxt_state.out_flop = ~state_ff.out_flop;
         end
         dtp_pkg::MODE_16BIT:
         begin
            // lo compare alone neither clears nor interrupts
            if (lo_step)
               nxt_state.cnt_lo = lo_inc;
            if (carry16)
               nxt_state.cnt_hi = hi_inc;
            if (match16)
            begin
               nxt_state.cnt_lo = 8'h00;
               nxt_state.cnt_hi = 8'h00;
               nxt_state.irq_hi = 1'b1;
               if (state_ff.ff_inv)
                  nxt_state.out_flop = ~state_ff.out_flop;
            end
         end
         dtp_pkg::MODE_PPG:
         begin
            if (ppg_step)
               nxt_state.cnt_lo = ppg_hi_eq ? 8'h00 : lo_inc;
            if (state_ff.ff_inv & (ppg_lo_eq ^ ppg_hi_eq))
               nxt_state.out_flop = ~state_ff.out_flop;
            if (ppg_hi_eq & dbuf_en)
               nxt_state.cmp_lo = state_ff.cmp_lo_buf;
         end
         default:
         begin
            // reserved mode code: nothing counts
            nxt_state.cnt_lo = state_ff.cnt_lo;
         end
      endcase

      if (!lo_run)
         nxt_state.cnt_lo = 8'h00;
      if (!hi_run)
         nxt_state.cnt_hi = 8'h00;

      ////////////////////////////////////////////////////////////////////
      if (wr_in)
      begin
         unique case (addr_in)
            dtp_pkg::ADDR_MODE:
               nxt_state.mode = wdata_in;
            dtp_pkg::ADDR_RUN:
               nxt_state.run = wdata_in;
            dtp_pkg::ADDR_CMP_LO:
            begin
               nxt_state.cmp_susp   = 1'b1;
               nxt_state.cmp_lo_buf = wdata_in;
               // in square wave mode with buffering the active value waits for compare_hi match
               if (!(dbuf_en & (mode_f == dtp_pkg::MODE_PPG)))
                  nxt_state.cmp_lo = wdata_in;
            end
            dtp_pkg::ADDR_CMP_HI:
            begin
               nxt_state.cmp_hi   = wdata_in;
               nxt_state.cmp_susp = 1'b0;
            end
            dtp_pkg::ADDR_FFCTRL:
            begin
               nxt_state.ff_inv = wdata_in[dtp_pkg::FF_INV_BIT];
               nxt_state.ff_sel = wdata_in[dtp_pkg::FF_SEL_BIT];
               // software preset wins over a same-cycle hardware toggle
               unique case (ff_cmd)
                  dtp_pkg::FF_INVERT:
                     nxt_state.out_flop = ~state_ff.out_flop;
                  dtp_pkg::FF_SET:
                     nxt_state.out_flop = 1'b1;
                  dtp_pkg::FF_CLEAR:
                     nxt_state.out_flop = 1'b0;
                  dtp_pkg::FF_CMD_RD:
                     nxt_state.out_flop = nxt_state.out_flop;
               endcase
            end
            default:
               nxt_state.rdata = 8'h00;
         endcase
      end

      if (rd_in)
      begin
         unique case (addr_in)
            dtp_pkg::ADDR_MODE:   nxt_state.rdata = state_ff.mode;
            dtp_pkg::ADDR_RUN:    nxt_state.rdata = state_ff.run;
            dtp_pkg::ADDR_CMP_LO: nxt_state.rdata = state_ff.cmp_lo;
            dtp_pkg::ADDR_CMP_HI: nxt_state.rdata = state_ff.cmp_hi;
            dtp_pkg::ADDR_FFCTRL:
               nxt_state.rdata = {4'h0, dtp_pkg::FF_CMD_RD,
                                  state_ff.ff_inv, state_ff.ff_sel};
            dtp_pkg::ADDR_CNT_LO: nxt_state.rdata = state_ff.cnt_lo;
            dtp_pkg::ADDR_CNT_HI: nxt_state.rdata = state_ff.cnt_hi;
            default:              nxt_state.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_ff            <= '0;
         state_ff.mode       <= dtp_pkg::MODE_RST;
         state_ff.run        <= dtp_pkg::RUN_RST;
         state_ff.cmp_lo     <= dtp_pkg::CMP_RST;
         state_ff.cmp_lo_buf <= dtp_pkg::CMP_RST;
         state_ff.cmp_hi     <= dtp_pkg::CMP_RST;
         state_ff.cnt_lo     <= dtp_pkg::CNT_RST;
         state_ff.cnt_hi     <= dtp_pkg::CNT_RST;
      end
      else
         state_ff <= nxt_state;
   end

   assign rdata_out         = state_ff.rdata;
   assign timer_out_pin_out = state_ff.out_flop;
   assign irq_lo_out        = state_ff.irq_lo;
   assign irq_hi_out        = state_ff.irq_hi;

   ////////////////////////////////////////////////////////////////////////
   default clocking dtp_cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   irq_lo_mode_a: assert property (irq_lo_out |->
      $past(mode_f) == dtp_pkg::MODE_8BIT)
      else $error("irq_lo outside 8-bit mode");

   match16_clear_a: assert property (
      (irq_hi_out && $past(mode_f) == dtp_pkg::MODE_16BIT) |->
      (state_ff.cnt_lo == 8'h00 && state_ff.cnt_hi == 8'h00))
      else $error("16-bit match did not clear counters");

   stop_clears_a: assert property (!lo_run |=>
      state_ff.cnt_lo == 8'h00)
      else $error("stopped lo counter not zero");

   preset_set_a: assert property (
      (wr_ff_ctrl && ff_cmd == dtp_pkg::FF_SET) |=> timer_out_pin_out)
      else $error("preset to one failed");

   preset_clr_a: assert property (
      (wr_ff_ctrl && ff_cmd == dtp_pkg::FF_CLEAR) |=> !timer_out_pin_out)
      else $error("preset to zero failed");

   susp_mask_a: assert property (state_ff.cmp_susp |=>
      !irq_lo_out && !irq_hi_out)
      else $error("match while compare suspended");

   susp_resume_a: assert property (
      (wr_in && addr_in == dtp_pkg::ADDR_CMP_HI) |=> !state_ff.cmp_susp)
      else $error("compare not resumed");

   step_one_a: assert property (
      (lo_step && !lo_match8 && mode_f == dtp_pkg::MODE_8BIT) |=>
      state_ff.cnt_lo == $past(lo_inc))
      else $error("lo counter did not step by one");

   period_clear_a: assert property (lo_match8 |=>
      state_ff.cnt_lo == 8'h00 ##1 irq_lo_out == 1'b0)
      else $error("lo counter not cleared at match");

   ppg_toggle_a: assert property (
      (ppg_hi_eq && state_ff.ff_inv && !wr_ff_ctrl) |=>
      timer_out_pin_out != $past(timer_out_pin_out))
      else $error("square wave did not toggle");

   dbuf_load_a: assert property ((ppg_hi_eq && dbuf_en) |=>
      state_ff.cmp_lo == $past(state_ff.cmp_lo_buf))
      else $error("buffered compare not loaded");

   stop_clears_hi_a: assert property (!hi_run |=>
      state_ff.cnt_hi == 8'h00)
      else $error("stopped hi counter not zero");

   carry_step_a: assert property ((carry16 && !match16) |=>
      state_ff.cnt_hi == $past(hi_inc))
      else $error("hi counter missed lo overflow step");

   ppg_lo_toggle_a: assert property (
      (ppg_lo_eq && !ppg_hi_eq && state_ff.ff_inv && !wr_ff_ctrl) |=>
      timer_out_pin_out != $past(timer_out_pin_out))
      else $error("square wave missed low compare toggle");

   // in square wave mode the lo counter must freeze while the hi run bit is clear
   ppg_hold_a: assert property (
      (mode_f == dtp_pkg::MODE_PPG && lo_run && !hi_run) |=>
      state_ff.cnt_lo == $past(state_ff.cnt_lo))
      else $error("square wave counted without hi run");

   cov_irq_lo_c: cover property (irq_lo_out);
   cov_16bit_c:  cover property (irq_hi_out &&
                                 mode_f == dtp_pkg::MODE_16BIT);
   cov_ppg_c:    cover property (ppg_hi_eq && state_ff.ff_inv);
   cov_dbuf_c:   cover property (ppg_hi_eq && dbuf_en);
   cov_pin_c:    cover property (lo_step &&
                                 lo_sel == dtp_pkg::CLK_SEL_0);
endmodule

//--- common/dtp_pkg.sv
// constants, field layout and helpers for the dual 8-bit timer pair
// Operation
// - 8-bit mode: two independent interval timers, each with own counter and irq.
// - mode field: 00 two 8-bit timers, 01 cascaded 16-bit, 10 square wave.
// - lo clock: pin, div1, div4, div16; hi clock: lo match, div1, div16, div256.
// - 8-bit mode: hi timer irq once every compare count of its clock.
// - output flop toggles each interval and drives the timer output pin.
// - 8-bit mode: lo or hi match may toggle the output flop.
// - hi clock set to lo match: hi counts one per lo match.
// - 16-bit mode: hi clocked by lo overflow, hi clock select ignored.
// - 16-bit mode: compare_lo low byte, compare_hi high byte of interval.
// - compare_lo write suspends compare; compare_hi write resumes it.
// - 16-bit mode: lo compare neither clears lo counter nor raises irq_lo.
// - 16-bit match: both counters clear, irq_hi, flop toggles if enabled.
// - square wave: toggle when lo counter hits compare_lo and compare_hi.
// - square wave: hi counter unused, hi run bit must still be set.
// - square wave double buffer: buffered compare_lo loads on compare_hi match.
// - flop control 01 presets flop to one, 10 clears it.
// - clearing a run bit stops that timer and zeroes its counter.
// - mode bits 1:0 pick lo clock, 01 is div1; bits 3:2 hi clock.
// - 8-bit mode: select bit picks lo or hi match as toggle source.
package dtp_pkg;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_RUN    = 4'h1;
   localparam logic [3:0] ADDR_CMP_LO = 4'h2;
   localparam logic [3:0] ADDR_CMP_HI = 4'h3;
   localparam logic [3:0] ADDR_FFCTRL = 4'h4;
   localparam logic [3:0] ADDR_CNT_LO = 4'h5;
   localparam logic [3:0] ADDR_CNT_HI = 4'h6;
   ////////////////////////////////////////////////////////////////////////
   localparam int MODE_LSB     = 6;
   localparam int HI_CLK_LSB   = 2;
   localparam int LO_CLK_LSB   = 0;
   localparam int RUN_LO_BIT   = 0;
   localparam int RUN_HI_BIT   = 1;
   localparam int RUN_PRE_BIT  = 2;
   localparam int RUN_DBUF_BIT = 7;
   localparam int FF_CMD_LSB   = 2;
   localparam int FF_INV_BIT   = 1;
   localparam int FF_SEL_BIT   = 0;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [1:0] MODE_8BIT  = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_PPG   = 2'h2;
   localparam logic [1:0] CLK_SEL_0  = 2'h0;
   localparam logic [1:0] CLK_SEL_1  = 2'h1;
   localparam logic [1:0] CLK_SEL_2  = 2'h2;
   localparam logic [1:0] FF_INVERT  = 2'h0;
   localparam logic [1:0] FF_SET     = 2'h1;
   localparam logic [1:0] FF_CLEAR   = 2'h2;
   localparam logic [1:0] FF_CMD_RD  = 2'h3;
   ////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] RUN_RST  = 8'h00;
   localparam logic [7:0] CMP_RST  = 8'h00;
   localparam logic [7:0] CNT_RST  = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // tap periods in sys clocks: 4, 16, 64, 1024
   localparam int         PRE_W     = 10;
   localparam logic [9:0] TAP1_MSK  = 10'h003;
   localparam logic [9:0] TAP4_MSK  = 10'h00f;
   localparam logic [9:0] TAP16_MSK = 10'h03f;
   localparam logic [9:0] TAP256_MSK = 10'h3ff;

   function automatic logic tap_hit(input logic [9:0] cnt,
                                    input logic [9:0] msk);
      tap_hit = ((cnt & msk) == msk);
   endfunction
endpackage

//--- verilog/dtp_prescaler.sv
// prescaler, counting while its run bit is set, producing the four tap pulses
`timescale 1ns/1ps
module dtp_prescaler
(
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic run_in,
   output logic      tap_div1_out,
   output logic      tap_div4_out,
   output logic      tap_div16_out,
   output logic      tap_div256_out
);
   typedef struct packed
   {
      logic [9:0] cnt;
      logic [3:0] taps;
   } dtp_pre_t;

   dtp_pre_t state_ff;
   dtp_pre_t nxt_state;

   always_comb
   begin
      nxt_state      = state_ff;
      nxt_state.taps = 4'h0;
      if (run_in)
      begin
         nxt_state.cnt  = state_ff.cnt + 10'h001;
         nxt_state.taps = {dtp_pkg::tap_hit(state_ff.cnt, dtp_pkg::TAP256_MSK),
                           dtp_pkg::tap_hit(state_ff.cnt, dtp_pkg::TAP16_MSK),
                           dtp_pkg::tap_hit(state_ff.cnt, dtp_pkg::TAP4_MSK),
                           dtp_pkg::tap_hit(state_ff.cnt, dtp_pkg::TAP1_MSK)};
      end
      else
         nxt_state.cnt = 10'h000;
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign tap_div1_out   = state_ff.taps[0];
   assign tap_div4_out   = state_ff.taps[1];
   assign tap_div16_out  = state_ff.taps[2];
   assign tap_div256_out = state_ff.taps[3];
endmodule

//--- verilog/dtp_pin_sync.sv
// three-flop synchroniser with rising edge pulse for the count pin
`timescale 1ns/1ps
module dtp_pin_sync
(
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic pin_in,
   output logic      rise_out
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } dtp_sync_t;

   dtp_sync_t state_ff;
   dtp_sync_t nxt_state;

   always_comb
   begin
      nxt_state      = state_ff;
      nxt_state.s1   = pin_in;
      nxt_state.s2   = state_ff.s1;
      nxt_state.s3   = state_ff.s2;
      nxt_state.rise = 1'b0;
      // only a level seen by two flops in a row counts
      if (state_ff.s2 == state_ff.s3)
      begin
         nxt_state.level = state_ff.s3;
         nxt_state.rise  = state_ff.s3 & ~state_ff.level;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign rise_out = state_ff.rise;
endmodule

//--- dv/tb_top.sv
// self-checking bench for the dual 8-bit timer pair
`timescale 1ns/1ps
module tb_top;
   localparam int LIMIT = 60000;
   logic       sys_clk_in;
   logic       rst_n_in;
   logic [3:0] addr_in;
   logic [7:0] wdata_in;
   logic       wr_in;
   logic       rd_in;
   logic       ext_count_pin_in;
   logic [7:0] rdata_out;
   logic       timer_out_pin_out;
   logic       irq_lo_out;
   logic       irq_hi_out;
   int         fail_count = 0;
   int         tests_run = 0;
   int         cycles = 0;
   int         lo_cnt = 0;
   int         hi_cnt = 0;
   int         a, b, c, n, k;
   logic       lv;
   logic [7:0] d;

   dtp_top u_dut
   (
      .sys_clk_in        (sys_clk_in),
      .rst_n_in          (rst_n_in),
      .addr_in           (addr_in),
      .wdata_in          (wdata_in),
      .wr_in             (wr_in),
      .rd_in             (rd_in),
      .ext_count_pin_in  (ext_count_pin_in),
      .rdata_out         (rdata_out),
      .timer_out_pin_out (timer_out_pin_out),
      .irq_lo_out        (irq_lo_out),
      .irq_hi_out        (irq_hi_out)
   );

   initial
   begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end

   // hang guard, plus a tally of irq pulses
   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (irq_lo_out === 1'b1)
         lo_cnt++;
      if (irq_hi_out === 1'b1)
         hi_cnt++;
      if (cycles == LIMIT)
      begin
         fail_count++;
         $display("unexpected run length: expected end seen %0d", cycles);
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
      @(posedge sys_clk_in);
      addr_in  <= ad;
      wdata_in <= dt;
      wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      wr_in    <= 1'b0;
   endtask

   // read data live only in the cycle after the strobe
   task automatic rc(input string nm, input logic [3:0] ad,
                     input logic [7:0] e);
      @(posedge sys_clk_in);
      addr_in <= ad;
      rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      rd_in   <= 1'b0;
      #1;
      chk(nm, 16'(e), 16'(rdata_out));
   endtask

   function automatic logic [7:0] mb(input logic [1:0] m, h, l);
      return {m, 2'b00, h, l};
   endfunction

   function automatic logic sig(input int s);
      return (s == 0) ? irq_lo_out : ((s == 1) ? irq_hi_out
                                               : timer_out_pin_out);
   endfunction

   // cycles between two events: irq rise or pin change; -1 if none
   task automatic gap(input int s, output int g, output logic l);
      logic p;
      int   e;
      e = 0;
      g = -1;
      // step off the edge that may have just moved the output
      #1;
      p = sig(s);
      for (int i = 0; i < 5000 && e < 2; i++)
      begin
         @(posedge sys_clk_in);
         #1;
         l = sig(s);
         if (e == 1)
            g++;
         if ((s < 2) ? (l === 1'b1 && p === 1'b0) : (l !== p))
         begin
            e++;
            if (e == 1)
               g = 0;
         end
         p = l;
      end
      if (e < 2)
         g = -1;
   endtask

   // stop first, since config changes on a running pair are unsafe
   task automatic cfg(input logic [7:0] md, lo, hi, ff);
      wr(dtp_pkg::ADDR_RUN, 8'h00);
      wr(dtp_pkg::ADDR_MODE, md);
      wr(dtp_pkg::ADDR_CMP_LO, lo);
      wr(dtp_pkg::ADDR_CMP_HI, hi);
      wr(dtp_pkg::ADDR_FFCTRL, ff);
   endtask

   task automatic pulse();
      int w;
      @(posedge sys_clk_in);
      w = 3 + $urandom % 4;
      ext_count_pin_in <= 1'b1;
      repeat (w) @(posedge sys_clk_in);
      ext_count_pin_in <= 1'b0;
      repeat (w) @(posedge sys_clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 8'h00;
      wr_in = 1'b0;
      rd_in = 1'b0;
      ext_count_pin_in = 1'b0;
      void'($urandom(32'hc200));
      repeat (20) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 7; i++)
         rc("reset value", 4'(i), (i == 4) ? 8'h0c : 8'h00);
      rc("unmapped", 4'hf, 8'h00);
      wr(dtp_pkg::ADDR_CNT_LO, 8'h55);
      rc("counter write", dtp_pkg::ADDR_CNT_LO, 8'h00);
      $display("test registers finished");
      a = 2 + $urandom % 8;
      b = 2 + $urandom % 8;
      cfg(mb(dtp_pkg::MODE_8BIT, dtp_pkg::CLK_SEL_1, dtp_pkg::CLK_SEL_1),
          8'(a), 8'(b), 8'h0e);
      wr(dtp_pkg::ADDR_RUN, 8'h07);
      gap(0, n, lv);
      chk("irq_lo period", 16'(a * 4), 16'(n));
      gap(1, n, lv);
      chk("irq_hi period", 16'(b * 4), 16'(n));
      gap(2, n, lv);
      chk("pin lo toggle", 16'(a * 4), 16'(n));
      wr(dtp_pkg::ADDR_FFCTRL, 8'h0f);
      gap(2, n, lv);
      chk("pin hi toggle", 16'(b * 4), 16'(n));
      $display("test eight_bit finished");
      a = 2 + $urandom % 4;
      b = 2 + $urandom % 4;
      cfg(mb(dtp_pkg::MODE_8BIT, dtp_pkg::CLK_SEL_0, dtp_pkg::CLK_SEL_1),
          8'(a), 8'(b), 8'h0f);
      wr(dtp_pkg::ADDR_RUN, 8'h07);
      gap(1, n, lv);
      chk("cascade period", 16'(a * b * 4), 16'(n));
      gap(2, n, lv);
      chk("cascade pin", 16'(a * b * 4), 16'(n));
      $display("test cascade finished");
      a = $urandom % 256;
      cfg(mb(dtp_pkg::MODE_16BIT, dtp_pkg::CLK_SEL_2, dtp_pkg::CLK_SEL_1),
          8'(a), 8'h01, 8'h0e);
      wr(dtp_pkg::ADDR_RUN, 8'h07);
      k = lo_cnt;
      gap(1, n, lv);
      chk("wide period", 16'((256 + a) * 4), 16'(n));
      gap(2, n, lv);
      chk("wide pin", 16'((256 + a) * 4), 16'(n));
      chk("wide irq_lo", 16'(k), 16'(lo_cnt));
      // counting goes on while suspended; only the match is masked
      wr(dtp_pkg::ADDR_CMP_LO, 8'(a));
      k = hi_cnt;
      repeat ((256 + a) * 4 + 8) @(posedge sys_clk_in);
      chk("suspended irq_hi", 16'(k), 16'(hi_cnt));
      rc("compare lo", dtp_pkg::ADDR_CMP_LO, 8'(a));
      wr(dtp_pkg::ADDR_RUN, 8'h00);
      rc("stopped lo", dtp_pkg::ADDR_CNT_LO, 8'h00);
      rc("stopped hi", dtp_pkg::ADDR_CNT_HI, 8'h00);
      wr(dtp_pkg::ADDR_CMP_HI, 8'h01);
      rc("compare hi", dtp_pkg::ADDR_CMP_HI, 8'h01);
      wr(dtp_pkg::ADDR_RUN, 8'h07);
      gap(1, n, lv);
      chk("resumed period", 16'((256 + a) * 4), 16'(n));
      $display("test wide finished");
      a = 2 + $urandom % 5;
      b = a + 2 + $urandom % 6;
      cfg(mb(dtp_pkg::MODE_PPG, dtp_pkg::CLK_SEL_0, dtp_pkg::CLK_SEL_1),
          8'(a), 8'(b), 8'h0a);
      #1;
      chk("clear preset", 16'h0000, 16'(timer_out_pin_out));
      rc("flop ctrl", dtp_pkg::ADDR_FFCTRL, 8'h0e);
      wr(dtp_pkg::ADDR_FFCTRL, 8'h06);
      #1;
      chk("set preset", 16'h0001, 16'(timer_out_pin_out));
      wr(dtp_pkg::ADDR_RUN, 8'h05);
      gap(2, n, lv);
      chk("square no hi run", 16'hffff, 16'(n));
      wr(dtp_pkg::ADDR_RUN, 8'h87);
      for (int i = 0; i < 2; i++)
      begin
         gap(2, n, lv);
         chk("square phase", 16'(lv ? (b - a) * 4 : a * 4), 16'(n));
      end
      // align just after a high-compare match so the buffer stays pending
      if (lv !== 1'b1)
         gap(2, n, lv);
      c = a + 1;
      wr(dtp_pkg::ADDR_CMP_LO, 8'(c));
      wr(dtp_pkg::ADDR_CMP_HI, 8'(b));
      rc("active compare", dtp_pkg::ADDR_CMP_LO, 8'(a));
      gap(2, n, lv);
      gap(2, n, lv);
      chk("buffered phase", 16'((b - c) * 4), 16'(n));
      $display("test square finished");
      cfg(mb(dtp_pkg::MODE_8BIT, dtp_pkg::CLK_SEL_1, dtp_pkg::CLK_SEL_0),
          8'h03, 8'h05, 8'h0e);
      wr(dtp_pkg::ADDR_RUN, 8'h01);
      k = lo_cnt;
      pulse();
      pulse();
      repeat (6) @(posedge sys_clk_in);
      rc("pin count", dtp_pkg::ADDR_CNT_LO, 8'h02);
      pulse();
      repeat (6) @(posedge sys_clk_in);
      rc("pin wrap", dtp_pkg::ADDR_CNT_LO, 8'h00);
      chk("pin irq", 16'(k + 1), 16'(lo_cnt));
      $display("test ext_pin finished");
      end_of_test();
   end
endmodule
